// ### hw/rdr_ctrl_pkg.sv
package rdr_ctrl_pkg;

    // Register indices (byte address = index, plain port)
    localparam logic [3:0] ADDR_OP_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_MODE_DEF = 4'h1;
    localparam logic [3:0] ADDR_CFG2     = 4'h2;
    localparam logic [3:0] ADDR_RX_CFG   = 4'h3;
    localparam logic [3:0] ADDR_DRV_UNMOD = 4'h4;
    localparam logic [3:0] ADDR_DRV_AM   = 4'h5;
    localparam logic [3:0] ADDR_MOD_DEPTH = 4'h6;
    localparam logic [3:0] ADDR_RX_STAT  = 4'h7;
    localparam logic [3:0] ADDR_CMD      = 4'h8;

    // Operation control bits
    localparam int OP_EN_BIT      = 7;
    localparam int OP_RX_EN_BIT   = 6;
    localparam int OP_RECEIVER_LOW_POWER_BIT   = 5;
    localparam int OP_TX_EN_BIT   = 3;
    localparam int OP_NFC_T_BIT   = 0;
    localparam logic [7:0] OP_CTRL_RST = 8'h00;

    // Mode definition: bits 7:3 mode, 2:0 filter preset
    localparam logic [4:0] MODE_NFC         = 5'h01;
    localparam logic [4:0] MODE_TRANSPARENT = 5'h1f;
    localparam int MODE_LSB = 3;

    // Config 2
    localparam int CFG2_ENV_EXT_BIT = 0;
    localparam int CFG2_PM_BIT      = 1;

    // Rx config: 7 agc_en, 6 agc_m, 5:3 filter, 2:0 manual gain cut
    localparam int RXC_AGC_EN_BIT = 7;
    localparam int RXC_AGC_M_BIT  = 6;
    localparam int RXC_FLT_LSB    = 3;

    localparam logic [7:0] DRV_UNMOD_RST = 8'hff;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    // Direct commands
    localparam logic [7:0] CMD_TRANSMIT      = 8'h01;
    localparam logic [7:0] CMD_RX_UNMASK     = 8'h02;
    localparam logic [7:0] CMD_MOD_CAL       = 8'h03;
    localparam logic [7:0] CMD_SQUELCH       = 8'h04;
    localparam logic [7:0] CMD_SQUELCH_CLEAR = 8'h05;
    localparam logic [7:0] CMD_SIG_CLEAR     = 8'h06;
    localparam logic [7:0] CMD_RX_MASK       = 8'h07;

    localparam logic [2:0] GAIN_MAX_STEP = 3'h7;
    localparam logic [3:0] AGC_PULSES    = 4'h8;
    localparam int SQ_MAX_TRANS = 2;

    // Timing at 100 MHz
    localparam int CLK_MHZ        = 100;
    localparam int AGC_DELAY_US   = 20;
    localparam int SQ_WINDOW_US   = 50;
    localparam int AGC_DELAY_CYC  = AGC_DELAY_US * CLK_MHZ;
    localparam int SQ_WINDOW_CYC  = SQ_WINDOW_US * CLK_MHZ;

    typedef enum logic [1:0] {SQ_IDLE, SQ_OBSERVE} sq_state_e;

endpackage

// ### hw/reader_mode_and_rx_gain_control.sv
// Notes on behaviour
// - Reset clears all operating bits; config writes still accepted in power-down.
// - Enable bit 7 powers oscillator and regulators; ready flagged once oscillator stable.
// - Receiver and transmitter have separate enables.
// - Receiver low power bit puts receiver into reduced power mode.
// - In target listen, external field detection pulses the host event.
// - Two drivers of eight segments; unmodulated register selects segments on.
// - AM level from calibrated depth command or directly written off-segments.
// - Receive window rises after every transmit, or by receive unmask command.
// - External envelope bypasses peak follower; PM selects phase detector.
// - Mode write loads filter selection into rx config, except in transparent mode; host may rewrite.
// - Automatic gain reduction starts 20 us after receive window rises.
// - Window mode 0 acts whole period; 1 only first 8 subcarrier pulses.
// - Automatic reduction steps 3 dB up to seven steps while comparator toggles.
// - Automatic reduction held reset while receive window is low.
// - Squelch counts transitions per 50 us; more than two cuts another step.
// - Squelch clear removes all squelch gain reduction.
// - Three-bit manual cut reduces gain in 3 dB steps.
// - Applied reduction sums all three sources; readable as gain_cut_readback.
// - Signal strength peak hold tracks while window high, frozen while low.
// - Four-bit strength readable in status; restarts when automatic reduction steps.
// - Signal strength clear command zeroes value and restarts peak hold.
`timescale 1ns/100ps
`default_nettype none

module reader_mode_and_rx_gain_control (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       osc_stable_i,
    input  wire logic       field_detect_i,
    input  wire logic       tx_done_i,
    input  wire logic       agc_cmp_i,
    input  wire logic       digitizer_i,
    input  wire logic       subcarrier_pulse_i,
    input  wire logic [3:0] strength_i,
    input  wire logic [7:0] cal_am_segments_i,
    output logic            osc_reg_en_o,
    output logic            ready_o,
    output logic            osc_stable_evt_o,
    output logic            field_evt_o,
    output logic            rx_en_o,
    output logic            tx_en_o,
    output logic            receiver_low_power_o,
    output logic            field_detector_en_o,
    output logic      [7:0] drv_unmod_o,
    output logic      [7:0] drv_am_o,
    output logic            mod_cal_start_o,
    output logic            receive_window_active_o,
    output logic      [1:0] demod_src_o,
    output logic      [2:0] rx_filter_o,
    output logic      [2:0] gain_cut_readback_o
);

    logic [7:0] op_ctrl_r;
    logic [7:0] mode_def_r;
    logic [7:0] cfg2_r;
    logic [7:0] rx_cfg_r;
    logic [7:0] drv_unmod_r;
    logic [7:0] drv_am_r;
    logic [7:0] mod_depth_r;
    logic [7:0] am_cal_r;
    logic       am_use_cal_r;
    logic [7:0] rdata_r;
    logic       rxw_r;
    logic       rxw_d_r;
    logic       osc_d_r;
    logic       fld_d_r;
    logic [12:0] agc_dly_r;
    logic        agc_run_r;
    logic [2:0]  agc_step_r;
    logic [3:0]  agc_pulse_r;
    logic        agc_cmp_d_r;
    logic        agc_trans_r;
    logic [12:0] agc_win_r;
    logic [2:0]  sq_step_r;
    logic [12:0] sq_tmr_r;
    logic [2:0]  sq_trans_r;
    logic        dig_d_r;
    logic [3:0]  rssi_r;
    logic [2:0]  gain_tot_r;
    rdr_ctrl_pkg::sq_state_e sq_state_r;

    logic cmd_wr;
    logic rxw_rise;
    logic agc_step_evt;

    assign cmd_wr   = wr_i && (addr_i == rdr_ctrl_pkg::ADDR_CMD);
    assign rxw_rise = rxw_r && !rxw_d_r;

    function automatic logic is_cmd(input logic [7:0] code);
        is_cmd = cmd_wr && (wdata_i == code);
    endfunction

    function automatic logic [2:0] sat_add(input logic [2:0] a, input logic [2:0] b);
        logic [3:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[3] ? rdr_ctrl_pkg::GAIN_MAX_STEP : s[2:0];
    endfunction

    // Register writes; accepted in every mode including power-down
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_ctrl_r   <= rdr_ctrl_pkg::OP_CTRL_RST;
            mode_def_r  <= rdr_ctrl_pkg::BYTE_ZERO;
            cfg2_r      <= rdr_ctrl_pkg::BYTE_ZERO;
            rx_cfg_r    <= rdr_ctrl_pkg::BYTE_ZERO;
            drv_unmod_r <= rdr_ctrl_pkg::DRV_UNMOD_RST;
            drv_am_r    <= rdr_ctrl_pkg::BYTE_ZERO;
            mod_depth_r <= rdr_ctrl_pkg::BYTE_ZERO;
        end else if (wr_i) begin
            case (addr_i)
                rdr_ctrl_pkg::ADDR_OP_CTRL:   op_ctrl_r   <= wdata_i;
                rdr_ctrl_pkg::ADDR_MODE_DEF: begin
                    mode_def_r <= wdata_i;
                    // Filter preset follows mode, except in transparent mode
                    if (wdata_i[7:rdr_ctrl_pkg::MODE_LSB] != rdr_ctrl_pkg::MODE_TRANSPARENT) begin
                        rx_cfg_r[rdr_ctrl_pkg::RXC_FLT_LSB +: 3] <= wdata_i[2:0];
                    end
                end
                rdr_ctrl_pkg::ADDR_CFG2:      cfg2_r      <= wdata_i;
                rdr_ctrl_pkg::ADDR_RX_CFG:    rx_cfg_r    <= wdata_i;
                rdr_ctrl_pkg::ADDR_DRV_UNMOD: drv_unmod_r <= wdata_i;
                rdr_ctrl_pkg::ADDR_DRV_AM:    drv_am_r    <= wdata_i;
                rdr_ctrl_pkg::ADDR_MOD_DEPTH: mod_depth_r <= wdata_i;
                default: ;
            endcase
        end
    end

    // AM level source: last of direct write or calibration wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            am_use_cal_r <= 1'b0;
            am_cal_r     <= rdr_ctrl_pkg::BYTE_ZERO;
        end else if (is_cmd(rdr_ctrl_pkg::CMD_MOD_CAL)) begin
            am_use_cal_r <= 1'b1;
            am_cal_r     <= cal_am_segments_i;
        end else if (wr_i && addr_i == rdr_ctrl_pkg::ADDR_DRV_AM) begin
            am_use_cal_r <= 1'b0;
        end
    end

    // Receive window control
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxw_r   <= 1'b0;
            rxw_d_r <= 1'b0;
        end else begin
            rxw_d_r <= rxw_r;
            if (tx_done_i || is_cmd(rdr_ctrl_pkg::CMD_TRANSMIT)
                    || is_cmd(rdr_ctrl_pkg::CMD_RX_UNMASK)) begin
                rxw_r <= 1'b1;
            end else if (is_cmd(rdr_ctrl_pkg::CMD_RX_MASK) || !op_ctrl_r[rdr_ctrl_pkg::OP_RX_EN_BIT]) begin
                rxw_r <= 1'b0;
            end
        end
    end

    // Event pulses for oscillator stable and external field
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_d_r <= 1'b0;
            fld_d_r <= 1'b0;
        end else begin
            osc_d_r <= osc_stable_i && op_ctrl_r[rdr_ctrl_pkg::OP_EN_BIT];
            fld_d_r <= field_detect_i && field_detector_en_o;
        end
    end

    // Automatic gain reduction, held in reset while window low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            agc_dly_r   <= '0;
            agc_run_r   <= 1'b0;
            agc_step_r  <= '0;
            agc_pulse_r <= '0;
            agc_cmp_d_r <= 1'b0;
            agc_trans_r <= 1'b0;
            agc_win_r   <= '0;
        end else if (!rxw_r || !rx_cfg_r[rdr_ctrl_pkg::RXC_AGC_EN_BIT]) begin
            agc_dly_r   <= '0;
            agc_run_r   <= 1'b0;
            agc_step_r  <= '0;
            agc_pulse_r <= '0;
            agc_cmp_d_r <= 1'b0;
            agc_trans_r <= 1'b0;
            agc_win_r   <= '0;
        end else if (!agc_run_r) begin
            if (agc_dly_r == 13'(rdr_ctrl_pkg::AGC_DELAY_CYC - 1)) begin
                agc_run_r <= 1'b1;
            end else begin
                agc_dly_r <= agc_dly_r + 13'h1;
            end
        end else begin
            agc_cmp_d_r <= agc_cmp_i;
            if (subcarrier_pulse_i && agc_pulse_r != rdr_ctrl_pkg::AGC_PULSES) begin
                agc_pulse_r <= agc_pulse_r + 4'h1;
            end
            // Transitions seen in a short observe slot cause one more step
            if (agc_win_r == 13'(rdr_ctrl_pkg::AGC_DELAY_CYC - 1)) begin
                agc_win_r   <= '0;
                agc_trans_r <= 1'b0;
                if (agc_step_evt) begin
                    agc_step_r <= agc_step_r + 3'h1;
                end
            end else begin
                agc_win_r <= agc_win_r + 13'h1;
                if (agc_cmp_i != agc_cmp_d_r) begin
                    agc_trans_r <= 1'b1;
                end
            end
        end
    end

    assign agc_step_evt = agc_trans_r && agc_step_r != rdr_ctrl_pkg::GAIN_MAX_STEP
        && (!rx_cfg_r[rdr_ctrl_pkg::RXC_AGC_M_BIT]
            || agc_pulse_r != rdr_ctrl_pkg::AGC_PULSES)
        && agc_win_r == 13'(rdr_ctrl_pkg::AGC_DELAY_CYC - 1);

    // Squelch: count digitizer transitions per 50 us slot
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sq_state_r <= rdr_ctrl_pkg::SQ_IDLE;
            sq_step_r  <= '0;
            sq_tmr_r   <= '0;
            sq_trans_r <= '0;
            dig_d_r    <= 1'b0;
        end else begin
            dig_d_r <= digitizer_i;
            if (is_cmd(rdr_ctrl_pkg::CMD_SQUELCH_CLEAR)) begin
                sq_state_r <= rdr_ctrl_pkg::SQ_IDLE;
                sq_step_r  <= '0;
            end else begin
                case (sq_state_r)
                    rdr_ctrl_pkg::SQ_IDLE: begin
                        sq_tmr_r   <= '0;
                        sq_trans_r <= '0;
                        if (is_cmd(rdr_ctrl_pkg::CMD_SQUELCH)) begin
                            sq_state_r <= rdr_ctrl_pkg::SQ_OBSERVE;
                        end
                    end
                    rdr_ctrl_pkg::SQ_OBSERVE: begin
                        if (sq_tmr_r == 13'(rdr_ctrl_pkg::SQ_WINDOW_CYC - 1)) begin
                            sq_tmr_r   <= '0;
                            sq_trans_r <= '0;
                            if (sq_trans_r > 3'(rdr_ctrl_pkg::SQ_MAX_TRANS)
                                    && sq_step_r != rdr_ctrl_pkg::GAIN_MAX_STEP) begin
                                sq_step_r <= sq_step_r + 3'h1;
                            end else begin
                                sq_state_r <= rdr_ctrl_pkg::SQ_IDLE;
                            end
                        end else begin
                            sq_tmr_r <= sq_tmr_r + 13'h1;
                            // Counter saturates; anything above two already decides
                            if (digitizer_i != dig_d_r && sq_trans_r != 3'h7) begin
                                sq_trans_r <= sq_trans_r + 3'h1;
                            end
                        end
                    end
                    default: sq_state_r <= rdr_ctrl_pkg::SQ_IDLE;
                endcase
            end
        end
    end

    // Combined gain reduction, saturating
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gain_tot_r <= '0;
        end else begin
            gain_tot_r <= sat_add(sat_add(agc_step_r, sq_step_r), rx_cfg_r[2:0]);
        end
    end

    // Signal strength peak hold
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rssi_r <= '0;
        end else if (is_cmd(rdr_ctrl_pkg::CMD_SIG_CLEAR) || rxw_rise || agc_step_evt) begin
            rssi_r <= '0;
        end else if (rxw_r && strength_i > rssi_r) begin
            rssi_r <= strength_i;
        end
    end

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= '0;
        end else if (rd_i) begin
            case (addr_i)
                rdr_ctrl_pkg::ADDR_OP_CTRL:   rdata_r <= op_ctrl_r;
                rdr_ctrl_pkg::ADDR_MODE_DEF:  rdata_r <= mode_def_r;
                rdr_ctrl_pkg::ADDR_CFG2:      rdata_r <= cfg2_r;
                rdr_ctrl_pkg::ADDR_RX_CFG:    rdata_r <= rx_cfg_r;
                rdr_ctrl_pkg::ADDR_DRV_UNMOD: rdata_r <= drv_unmod_r;
                rdr_ctrl_pkg::ADDR_DRV_AM:    rdata_r <= drv_am_o;
                rdr_ctrl_pkg::ADDR_MOD_DEPTH: rdata_r <= mod_depth_r;
                rdr_ctrl_pkg::ADDR_RX_STAT:   rdata_r <= {rssi_r, 1'b0, gain_tot_r};
                default:                      rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata_o              = rdata_r;
    assign osc_reg_en_o         = op_ctrl_r[rdr_ctrl_pkg::OP_EN_BIT];
    assign ready_o              = osc_d_r;
    assign osc_stable_evt_o     = osc_stable_i && op_ctrl_r[rdr_ctrl_pkg::OP_EN_BIT] && !osc_d_r;
    assign rx_en_o              = op_ctrl_r[rdr_ctrl_pkg::OP_RX_EN_BIT];
    assign tx_en_o              = op_ctrl_r[rdr_ctrl_pkg::OP_TX_EN_BIT];
    assign receiver_low_power_o = op_ctrl_r[rdr_ctrl_pkg::OP_RECEIVER_LOW_POWER_BIT];
    // Field detector only honoured in NFC mode
    assign field_detector_en_o  = op_ctrl_r[rdr_ctrl_pkg::OP_NFC_T_BIT]
        && mode_def_r[7:rdr_ctrl_pkg::MODE_LSB] == rdr_ctrl_pkg::MODE_NFC;
    assign field_evt_o          = field_detect_i && field_detector_en_o && !fld_d_r;
    assign drv_unmod_o          = drv_unmod_r;
    assign drv_am_o             = am_use_cal_r ? am_cal_r : drv_am_r;
    assign mod_cal_start_o      = is_cmd(rdr_ctrl_pkg::CMD_MOD_CAL);
    assign receive_window_active_o = rxw_r;
    assign demod_src_o          = {cfg2_r[rdr_ctrl_pkg::CFG2_PM_BIT],
                                   cfg2_r[rdr_ctrl_pkg::CFG2_ENV_EXT_BIT]};
    assign rx_filter_o          = rx_cfg_r[rdr_ctrl_pkg::RXC_FLT_LSB +: 3];
    assign gain_cut_readback_o  = gain_tot_r;

endmodule // reader_mode_and_rx_gain_control

`default_nettype wire

// ### test/rdr_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rdr_ctrl_assertions (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       osc_stable_i,
    input wire logic       field_detect_i,
    input wire logic       tx_done_i,
    input wire logic       osc_reg_en_o,
    input wire logic       ready_o,
    input wire logic       field_evt_o,
    input wire logic       field_detector_en_o,
    input wire logic       rx_en_o,
    input wire logic [7:0] drv_unmod_o,
    input wire logic       mod_cal_start_o,
    input wire logic       receive_window_active_o,
    input wire logic [1:0] demod_src_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence wr_at(logic [3:0] a);
        wr_i && addr_i == a;
    endsequence
    sequence unmask_cmd;
        wr_at(rdr_ctrl_pkg::ADDR_CMD) ##0 wdata_i == rdr_ctrl_pkg::CMD_RX_UNMASK && rx_en_o;
    endsequence
    op_enable_a: assert property (wr_at(rdr_ctrl_pkg::ADDR_OP_CTRL) |=> osc_reg_en_o == $past(wdata_i[7])) else $error("enable bit not applied");
    ready_gate_a: assert property (ready_o |-> $past(osc_reg_en_o && osc_stable_i)) else $error("ready without stable oscillator");
    field_event_a: assert property (field_evt_o |-> field_detector_en_o && $rose(field_detect_i)) else $error("spurious field event");
    cal_pulse_a: assert property (mod_cal_start_o == (wr_i && addr_i == rdr_ctrl_pkg::ADDR_CMD && wdata_i == rdr_ctrl_pkg::CMD_MOD_CAL)) else $error("calibrate start mismatch");
    tx_window_a: assert property (tx_done_i && rx_en_o |=> receive_window_active_o) else $error("window not opened by transmit");
    unmask_window_a: assert property (unmask_cmd |=> receive_window_active_o) else $error("window not opened by unmask");
    demod_sel_a: assert property (wr_at(rdr_ctrl_pkg::ADDR_CFG2) |=> demod_src_o == $past(wdata_i[1:0])) else $error("demod source wrong");
    unmod_load_a: assert property (wr_at(rdr_ctrl_pkg::ADDR_DRV_UNMOD) |=> drv_unmod_o == $past(wdata_i)) else $error("segment load wrong");
    unmod_hold_a: assert property (!wr_i |=> $stable(drv_unmod_o)) else $error("segments changed unwritten");
    unmapped_read_a: assert property (rd_i && addr_i > 4'h8 |=> rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule // rdr_ctrl_assertions
bind reader_mode_and_rx_gain_control rdr_ctrl_assertions chk_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .osc_stable_i(osc_stable_i),
    .field_detect_i(field_detect_i), .tx_done_i(tx_done_i), .osc_reg_en_o(osc_reg_en_o),
    .ready_o(ready_o), .field_evt_o(field_evt_o), .field_detector_en_o(field_detector_en_o),
    .rx_en_o(rx_en_o), .drv_unmod_o(drv_unmod_o), .mod_cal_start_o(mod_cal_start_o),
    .receive_window_active_o(receive_window_active_o), .demod_src_o(demod_src_o)
);
`default_nettype wire

// ### test/rdr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rdr_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
    task automatic cmd(input logic [7:0] c);
        wr_reg(rdr_ctrl_pkg::ADDR_CMD, c);
    endtask
    // Filter must be written by hand, the mode register is ignored here
    task automatic set_transparent(input logic [2:0] f);
        wr_reg(rdr_ctrl_pkg::ADDR_MODE_DEF, {rdr_ctrl_pkg::MODE_TRANSPARENT, 3'h0});
        wr_reg(rdr_ctrl_pkg::ADDR_RX_CFG, {2'b00, f, 3'h0});
    endtask
    task automatic enter_listen(input logic [2:0] f);
        wr_reg(rdr_ctrl_pkg::ADDR_MODE_DEF, {rdr_ctrl_pkg::MODE_NFC, f});
        wr_reg(rdr_ctrl_pkg::ADDR_OP_CTRL, 8'h01);
    endtask
    task automatic wake();
        wr_reg(rdr_ctrl_pkg::ADDR_OP_CTRL, 8'hc0);
    endtask
endmodule // rdr_host_model
`default_nettype wire

// ### test/reader_mode_and_rx_gain_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module reader_mode_and_rx_gain_control_tb_top;
    logic       clk_i = 1'b0, nrst_i = 1'b0, wr, rd, noise = 1'b0;
    logic       osc_stable_i = 1'b0, field_detect_i = 1'b0, tx_done_i = 1'b0;
    logic       agc_cmp_i = 1'b0, digitizer_i = 1'b0, sc_pulse = 1'b0;
    logic       osc_en, ready, osc_evt, field_evt, rx_en, tx_en, receiver_low_power, fd_en, cal_go, win;
    logic [3:0] addr, strength_i = 4'h0;
    logic [7:0] wdata, rdata, rd_v, unmod, am, v, cal_am = 8'h00;
    logic [1:0] demod;
    logic [2:0] flt, gain;
    int         seed = 8072;
    int         bad_count = 0;
    int         num_checks = 0;
    int         peak;

    always #5 clk_i = ~clk_i;
    // Toggling every cycle is far above the two-transition threshold
    always @(posedge clk_i) if (noise) begin
        agc_cmp_i <= ~agc_cmp_i;
        digitizer_i <= ~digitizer_i;
        sc_pulse <= ~sc_pulse;
    end

    reader_mode_and_rx_gain_control reader_mode_and_rx_gain_control_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .osc_stable_i(osc_stable_i), .field_detect_i(field_detect_i),
        .tx_done_i(tx_done_i), .agc_cmp_i(agc_cmp_i), .digitizer_i(digitizer_i),
        .subcarrier_pulse_i(sc_pulse), .strength_i(strength_i), .cal_am_segments_i(cal_am),
        .osc_reg_en_o(osc_en), .ready_o(ready), .osc_stable_evt_o(osc_evt),
        .field_evt_o(field_evt), .rx_en_o(rx_en), .tx_en_o(tx_en),
        .receiver_low_power_o(receiver_low_power), .field_detector_en_o(fd_en), .drv_unmod_o(unmod),
        .drv_am_o(am), .mod_cal_start_o(cal_go), .receive_window_active_o(win),
        .demod_src_o(demod), .rx_filter_o(flt), .gain_cut_readback_o(gain));
    rdr_host_model rdr_host_model_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] d);
        rdr_host_model_i.wr_reg(a, d);
    endtask
    task automatic c(input logic [7:0] x);
        rdr_host_model_i.cmd(x);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic st(input int p, input int g);
        rdr_host_model_i.rd_reg(rdr_ctrl_pkg::ADDR_RX_STAT, rd_v);
        chk("status", {4'(p), 1'b0, 3'(g)}, rd_v);
    endtask

    initial begin
        #800000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        cyc(1);
        chk("unmod_rst", 8'hff, unmod);
        chk("op_rst", 8'h00, {osc_en, rx_en, receiver_low_power, tx_en, fd_en, win, gain[1:0]});
        rdr_host_model_i.rd_reg(4'hc, rd_v);
        chk("unmapped", 8'h00, rd_v);
        rdr_host_model_i.set_transparent(3'h5);
        chk("flt_manual", 8'h05, {5'h0, flt});
        rdr_host_model_i.enter_listen(3'h2);
        chk("flt_auto", 8'h02, {5'h0, flt});
        chk("listen", 8'h01, {7'h0, fd_en});
        @(posedge clk_i);
        field_detect_i <= 1'b1;
        #1 chk("field_evt", 8'h01, {7'h0, field_evt});
        rdr_host_model_i.wake();
        @(posedge clk_i);
        osc_stable_i <= 1'b1;
        #1 chk("osc_evt", 8'h01, {7'h0, osc_evt});
        cyc(2);
        chk("ready", 8'h03, {6'h0, osc_en, ready});
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'h68 | 8'h80;
            w(rdr_ctrl_pkg::ADDR_OP_CTRL, v);
            chk("rx_tx", {5'h0, v[6], v[5], v[3]}, {5'h0, rx_en, receiver_low_power, tx_en});
        end
        v = 8'($random(seed));
        w(rdr_ctrl_pkg::ADDR_DRV_UNMOD, v);
        chk("unmod", v, unmod);
        v = 8'($random(seed));
        w(rdr_ctrl_pkg::ADDR_DRV_AM, v);
        chk("am_direct", v, am);
        @(posedge clk_i);
        cal_am <= ~v;
        c(rdr_ctrl_pkg::CMD_MOD_CAL);
        chk("am_cal", ~v, am);
        for (int i = 0; i < 4; i++) begin
            w(rdr_ctrl_pkg::ADDR_CFG2, 8'(i));
            chk("demod", 8'(i), {6'h0, demod});
        end
        w(rdr_ctrl_pkg::ADDR_OP_CTRL, 8'hc8);
        @(posedge clk_i);
        tx_done_i <= 1'b1;
        @(posedge clk_i);
        tx_done_i <= 1'b0;
        #1 chk("win_tx", 8'h01, {7'h0, win});
        c(rdr_ctrl_pkg::CMD_RX_MASK);
        chk("win_mask", 8'h00, {7'h0, win});
        c(rdr_ctrl_pkg::CMD_TRANSMIT);
        chk("win_cmd", 8'h01, {7'h0, win});
        c(rdr_ctrl_pkg::CMD_RX_MASK);
        c(rdr_ctrl_pkg::CMD_RX_UNMASK);
        chk("win_unmask", 8'h01, {7'h0, win});
        peak = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            strength_i <= 4'($random(seed));
            #1 peak = (int'(strength_i) > peak) ? int'(strength_i) : peak;
        end
        @(posedge clk_i);
        strength_i <= 4'h0;
        st(peak, 0);
        c(rdr_ctrl_pkg::CMD_RX_MASK);
        @(posedge clk_i);
        strength_i <= 4'hf;
        cyc(3);
        st(peak, 0);
        c(rdr_ctrl_pkg::CMD_SIG_CLEAR);
        st(0, 0);
        for (int i = 0; i < 8; i++) begin
            w(rdr_ctrl_pkg::ADDR_RX_CFG, 8'(i));
            cyc(2);
            chk("manual", 8'(i), {5'h0, gain});
        end
        st(0, 7);
        // AGC timing figures come from the package at 100 MHz
        w(rdr_ctrl_pkg::ADDR_RX_CFG, 8'h80);
        c(rdr_ctrl_pkg::CMD_RX_UNMASK);
        noise = 1'b1;
        // First step only at the end of the first slot after the start delay
        cyc(3900);
        chk("agc_delay", 8'h00, {5'h0, gain});
        cyc(150);
        chk("agc_step", 8'h01, {5'h0, gain});
        // Waits past the slot where an eighth step would wrap
        cyc(14050);
        chk("agc_sat", 8'h07, {5'h0, gain});
        c(rdr_ctrl_pkg::CMD_RX_MASK);
        cyc(2);
        chk("agc_reset", 8'h00, {5'h0, gain});
        w(rdr_ctrl_pkg::ADDR_RX_CFG, 8'hc0);
        c(rdr_ctrl_pkg::CMD_RX_UNMASK);
        cyc(4100);
        chk("agc_mode1", 8'h00, {5'h0, gain});
        c(rdr_ctrl_pkg::CMD_RX_MASK);
        w(rdr_ctrl_pkg::ADDR_RX_CFG, 8'h04);
        c(rdr_ctrl_pkg::CMD_SQUELCH);
        cyc(4900);
        chk("sq_slot", 8'h04, {5'h0, gain});
        cyc(200);
        chk("sq_step", 8'h05, {5'h0, gain});
        cyc(35000);
        chk("sq_sat", 8'h07, {5'h0, gain});
        noise = 1'b0;
        c(rdr_ctrl_pkg::CMD_SQUELCH_CLEAR);
        cyc(2);
        chk("sq_clear", 8'h04, {5'h0, gain});
        c(rdr_ctrl_pkg::CMD_SQUELCH);
        cyc(5100);
        chk("sq_quiet", 8'h04, {5'h0, gain});
        end_sim();
    end
endmodule // reader_mode_and_rx_gain_control_tb_top
`default_nettype wire
